//--- logic/mrr_pkg.sv
// constants and carrier types for the motion report register group
package mrr_pkg;
   // register addresses on the serial port
   localparam logic [6:0] MRR_ADDR_PART_ID = 7'h00;
   localparam logic [6:0] MRR_ADDR_SILICON_REV = 7'h01;
   localparam logic [6:0] MRR_ADDR_STATUS = 7'h02;
   localparam logic [6:0] MRR_ADDR_X_DISP = 7'h03;
   localparam logic [6:0] MRR_ADDR_Y_DISP = 7'h04;
   localparam logic [6:0] MRR_ADDR_SURFACE = 7'h05;
   localparam logic [6:0] MRR_ADDR_CONFIG = 7'h0a;
   localparam logic [6:0] MRR_ADDR_FLUSH = 7'h12;
   localparam logic [6:0] MRR_ADDR_FW_REV = 7'h1f;
   // address byte layout
   localparam int MRR_WRITE_BIT = 7;
   // status field positions
   localparam int MRR_PENDING_BIT = 7;
   localparam int MRR_OVERRUN_BIT = 4;
   localparam int MRR_STATUS_RES_BIT = 0;
   // configuration field position and values after reset
   localparam int MRR_CFG_RES_BIT = 4;
   localparam logic [7:0] MRR_CFG_RESET = 8'h09;
   localparam logic [7:0] MRR_CFG_WRITE_MASK = 8'h7f;
   localparam logic [7:0] MRR_DISP_RESET = 8'h00;
   localparam logic [7:0] MRR_SURFACE_RESET = 8'h00;
   localparam logic [7:0] MRR_SURFACE_MAX = 8'ha9;
   // accumulators hold high resolution counts
   localparam int MRR_ACC_W = 14;
   // positive limit is a whole number of full-scale reports at either
   // resolution, so a saturated axis drains in exactly 16 or 64 cycles
   localparam logic signed [13:0] MRR_ACC_MAX = 14'sh1fc0;
   localparam logic signed [13:0] MRR_ACC_MIN = 14'sh2000;
   localparam logic signed [13:0] MRR_ACC_RESET = 14'sh0000;
   // serial bit counts
   localparam logic [4:0] MRR_ADDR_LAST_BIT = 5'h07;
   localparam logic [4:0] MRR_DATA_FIRST_BIT = 5'h08;
   localparam logic [4:0] MRR_DATA_LAST_BIT = 5'h0f;
   localparam logic [4:0] MRR_FRAME_DONE = 5'h10;

   typedef struct packed {
      logic valid;
      logic signed [7:0] dx;
      logic signed [7:0] dy;
      logic [9:0] features;
   } mrr_frame_s;

   typedef struct packed {
      logic [4:0] cnt;
      logic [6:0] sh;
      logic [7:0] addr;
      logic [7:0] wdata;
      logic rd_req;
      logic wr_req;
   } mrr_link_s;

   typedef struct packed {
      logic miso;
      logic miso_oe;
   } mrr_out_s;

   typedef struct packed {
      logic signed [13:0] acc_x;
      logic signed [13:0] acc_y;
      logic [7:0] x_disp;
      logic [7:0] y_disp;
      logic pending;
      logic overrun;
      logic [7:0] surface;
      logic [7:0] config_bits;
      logic [7:0] fw_rev;
      logic [7:0] rdata;
      logic rd_s1;
      logic rd_s2;
      logic rd_prev;
      logic wr_s1;
      logic wr_s2;
      logic wr_prev;
   } mrr_sys_s;
endpackage

//--- logic/mrr_motion_report.sv
// motion report registers behind a four-wire serial port
// Operation
// RQ1: fixed part identity byte reads back
// RQ2: read-only silicon revision byte
// RQ3: firmware revision in its own register
// RQ4: status bit 7 flags pending motion
// RQ5: status bit 4 flags accumulator overrun
// RQ6: status bit 0 shows resolution
// RQ7: status read freezes displacement registers
// RQ8: status re-read discards old frozen values
// RQ9: host reads status, X, Y in order
// RQ10: wide saturating accumulators, overflow sets overrun
// RQ11: overrun clears after readout below full scale
// RQ12: remaining motion drains as full scale
// RQ13: host allows 16 or 64 drain cycles
// RQ14: flush write discards all stored motion
// RQ15: X register signed, scaled, clear on read
// RQ16: Y register signed, scaled, clear on read
// RQ17: surface count is features over four, capped
// RQ18: surface count refreshed every frame
// RQ19: reported resolution follows configuration bit
// RQ20: reserved status bits read zero
`timescale 1ns/1ps
module mrr_motion_report
   import mrr_pkg::*;
#(
   // arbitrary neutral values
   parameter logic [7:0] PART_IDENTITY_CODE = 8'h5a,
   parameter logic [7:0] SILICON_REVISION = 8'h02
) (
   // system clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // serial port, clock idles high
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_mosi,
   output logic spi_miso,
   output logic spi_miso_oe,
   // per-frame results from the imaging pipeline
   input wire mrr_frame_s frame,
   // revision of the loaded firmware
   input wire logic [7:0] firmware_revision_code
);

   mrr_link_s lk;
   mrr_link_s next_lk;
   mrr_out_s po;
   mrr_out_s next_po;
   mrr_sys_s s;
   mrr_sys_s next_s;

   logic rd_evt;
   logic wr_evt;
   logic [14:0] sat_x;
   logic [14:0] sat_y;
   logic [7:0] q_x;
   logic [7:0] q_y;
   logic res_hi;
   logic [7:0] surf_raw;

   // clamp at the limits; top bit returned is the overflow flag
   function automatic logic [14:0] sat_add(input logic signed [13:0] a,
                                           input logic signed [7:0] d);
      logic signed [14:0] sum;
      logic signed [14:0] hi_lim;
      logic signed [14:0] lo_lim;
      sum = {a[13], a} + {{7{d[7]}}, d};
      hi_lim = {MRR_ACC_MAX[13], MRR_ACC_MAX};
      lo_lim = {MRR_ACC_MIN[13], MRR_ACC_MIN};
      if (sum > hi_lim) begin
         sat_add = {1'b1, MRR_ACC_MAX};
      end else if (sum < lo_lim) begin
         sat_add = {1'b1, MRR_ACC_MIN};
      end else begin
         sat_add = {1'b0, sum[13:0]};
      end
   endfunction

   // low resolution floors toward minus infinity, leftover stays in acc
   function automatic logic [7:0] quant(input logic signed [13:0] a,
                                        input logic hi);
      logic [11:0] t;
      t = a[13:2];
      if (hi) begin
         if (a[13:7] == 7'h00 || a[13:7] == 7'h7f) begin
            quant = a[7:0];
         end else begin
            quant = a[13] ? 8'h80 : 8'h7f;
         end
      end else begin
         if (t[11:7] == 5'h00 || t[11:7] == 5'h1f) begin
            quant = t[7:0];
         end else begin
            quant = t[11] ? 8'h80 : 8'h7f;
         end
      end
   endfunction

   // amount taken out of the accumulator for a reported count
   function automatic logic signed [13:0] removed(input logic [7:0] q,
                                                  input logic hi);
      if (hi) begin
         removed = {{6{q[7]}}, q};
      end else begin
         removed = {{4{q[7]}}, q, 2'b00};
      end
   endfunction

   function automatic logic full_scale(input logic signed [13:0] a);
      full_scale = (a == MRR_ACC_MAX) || (a == MRR_ACC_MIN);
   endfunction

   // link side, sampled on rising sclk; chip select high ends the frame
   always_comb begin
      next_lk = lk;
      if (lk.cnt != MRR_FRAME_DONE) begin
         next_lk.cnt = lk.cnt + 5'h01;
         next_lk.sh = {lk.sh[5:0], spi_mosi};
      end
      if (lk.cnt == MRR_ADDR_LAST_BIT) begin
         next_lk.addr = {lk.sh, spi_mosi};
         next_lk.rd_req = ~lk.sh[6];
      end
      if (lk.cnt == MRR_DATA_LAST_BIT && lk.addr[MRR_WRITE_BIT]) begin
         next_lk.wdata = {lk.sh, spi_mosi};
         next_lk.wr_req = 1'b1;
      end
   end

   // request levels only fall with chip select, so sys sees one edge per frame
   always_ff @(posedge spi_sclk or posedge spi_cs_n) begin
      if (spi_cs_n) begin
         lk <= '0;
      end else begin
         lk <= next_lk;
      end
   end

   // read data shifted out msb first on falling sclk
   always_comb begin
      next_po.miso_oe = 1'b1;
      next_po.miso = po.miso;
      if (lk.cnt >= MRR_DATA_FIRST_BIT && lk.cnt <= MRR_DATA_LAST_BIT &&
          !lk.addr[MRR_WRITE_BIT]) begin
         // rdata is held still by the request handshake
         next_po.miso = s.rdata[3'(MRR_DATA_LAST_BIT - lk.cnt)];
      end
   end

   always_ff @(negedge spi_sclk or posedge spi_cs_n) begin
      if (spi_cs_n) begin
         po <= '0;
      end else begin
         po <= next_po;
      end
   end

   assign spi_miso = po.miso;
   assign spi_miso_oe = po.miso_oe;

   // system side
   assign rd_evt = s.rd_s2 & ~s.rd_prev;
   assign wr_evt = s.wr_s2 & ~s.wr_prev;
   // RQ19 resolution from config
   assign res_hi = s.config_bits[MRR_CFG_RES_BIT];
   assign q_x = quant(s.acc_x, res_hi);
   assign q_y = quant(s.acc_y, res_hi);

   always_comb begin
      next_s = s;
      sat_x = '0;
      sat_y = '0;
      surf_raw = frame.features[9:2];
      next_s.rd_s1 = lk.rd_req;
      next_s.rd_s2 = s.rd_s1;
      next_s.rd_prev = s.rd_s2;
      next_s.wr_s1 = lk.wr_req;
      next_s.wr_s2 = s.wr_s1;
      next_s.wr_prev = s.wr_s2;
      // RQ3 firmware revision capture
      next_s.fw_rev = firmware_revision_code;
      if (rd_evt) begin
         case (lk.addr[6:0])
            // RQ1 fixed identity
            MRR_ADDR_PART_ID: next_s.rdata = PART_IDENTITY_CODE;
            // RQ2 silicon revision
            MRR_ADDR_SILICON_REV: next_s.rdata = SILICON_REVISION;
            MRR_ADDR_STATUS: begin
               // RQ20 reserved bits zero
               next_s.rdata = 8'h00;
               // RQ4 pending flag
               next_s.rdata[MRR_PENDING_BIT] = s.pending;
               // RQ5 overrun flag
               next_s.rdata[MRR_OVERRUN_BIT] = s.overrun;
               // RQ6 resolution bit
               next_s.rdata[MRR_STATUS_RES_BIT] = res_hi;
               // RQ7 RQ8 freeze, overwriting unread values
               next_s.x_disp = q_x;
               next_s.y_disp = q_y;
               // RQ12 leftover drains in full-scale steps
               next_s.acc_x = s.acc_x - removed(q_x, res_hi);
               next_s.acc_y = s.acc_y - removed(q_y, res_hi);
               next_s.pending = (quant(next_s.acc_x, res_hi) != 8'h00) ||
                                (quant(next_s.acc_y, res_hi) != 8'h00);
            end
            MRR_ADDR_X_DISP: begin
               // RQ15 read clears X
               next_s.rdata = s.x_disp;
               next_s.x_disp = MRR_DISP_RESET;
               // RQ11 overrun clear below full scale
               if (!full_scale(s.acc_x) && !full_scale(s.acc_y)) begin
                  next_s.overrun = 1'b0;
               end
            end
            MRR_ADDR_Y_DISP: begin
               // RQ16 read clears Y
               next_s.rdata = s.y_disp;
               next_s.y_disp = MRR_DISP_RESET;
               // RQ11 overrun clear below full scale
               if (!full_scale(s.acc_x) && !full_scale(s.acc_y)) begin
                  next_s.overrun = 1'b0;
               end
            end
            MRR_ADDR_SURFACE: next_s.rdata = s.surface;
            MRR_ADDR_CONFIG: next_s.rdata = s.config_bits;
            MRR_ADDR_FW_REV: next_s.rdata = s.fw_rev;
            default: next_s.rdata = 8'h00;
         endcase
      end
      if (wr_evt) begin
         case (lk.addr[6:0])
            // RQ19 configuration write
            MRR_ADDR_CONFIG: next_s.config_bits = lk.wdata & MRR_CFG_WRITE_MASK;
            MRR_ADDR_FLUSH: begin
               // RQ14 flush all stored motion
               next_s.acc_x = MRR_ACC_RESET;
               next_s.acc_y = MRR_ACC_RESET;
               next_s.x_disp = MRR_DISP_RESET;
               next_s.y_disp = MRR_DISP_RESET;
               next_s.pending = 1'b0;
               next_s.overrun = 1'b0;
            end
            default: next_s.pending = next_s.pending;
         endcase
      end
      // frame applied after register accesses so new motion wins over any clear but reset
      if (frame.valid) begin
         // RQ10 saturate and flag overrun
         sat_x = sat_add(next_s.acc_x, frame.dx);
         sat_y = sat_add(next_s.acc_y, frame.dy);
         next_s.acc_x = sat_x[13:0];
         next_s.acc_y = sat_y[13:0];
         if (sat_x[14] || sat_y[14]) begin
            next_s.overrun = 1'b1;
         end
         // RQ4 motion marks data ready
         if (frame.dx != 8'sh00 || frame.dy != 8'sh00) begin
            next_s.pending = 1'b1;
         end
         // RQ17 RQ18 per-frame surface count
         next_s.surface = (surf_raw > MRR_SURFACE_MAX) ? MRR_SURFACE_MAX : surf_raw;
      end
      if (!resetn) begin
         next_s = '0;
         next_s.acc_x = MRR_ACC_RESET;
         next_s.acc_y = MRR_ACC_RESET;
         next_s.x_disp = MRR_DISP_RESET;
         next_s.y_disp = MRR_DISP_RESET;
         next_s.surface = MRR_SURFACE_RESET;
         next_s.config_bits = MRR_CFG_RESET;
      end
   end

   always_ff @(posedge clk_sys) begin
      s <= next_s;
   end

endmodule

//--- dv/mrr_sva.sv
// serial pin assertions for the motion report block
`timescale 1ns/1ps
module mrr_sva (
   // clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // serial port
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_miso,
   input wire logic spi_miso_oe
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   sequence s_fall;
      $fell(spi_sclk) && !spi_cs_n;
   endsequence
   sequence s_end;
      $rose(spi_cs_n);
   endsequence
   property p_idle;
      spi_cs_n |-> !spi_miso_oe && !spi_miso;
   endproperty
   a_idle: assert property (p_idle) else $error("miso active while deselected");
   property p_end;
      s_end |-> (!spi_miso_oe && !spi_miso) [*2];
   endproperty
   a_end: assert property (p_end) else $error("miso not released");
   property p_oe_rise;
      $rose(spi_miso_oe) |-> s_fall;
   endproperty
   a_oe_rise: assert property (p_oe_rise) else $error("enable off a falling edge");
   property p_oe_stands;
      spi_miso_oe && !spi_cs_n |=> spi_miso_oe || spi_cs_n;
   endproperty
   a_oe_stands: assert property (p_oe_stands) else $error("enable dropped");
   property p_miso_moves;
      $changed(spi_miso) && !spi_cs_n |-> s_fall;
   endproperty
   a_miso_moves: assert property (p_miso_moves) else $error("miso moved off edge");
   property p_oe_moves;
      $changed(spi_miso_oe) |-> $fell(spi_sclk) || spi_cs_n;
   endproperty
   a_oe_moves: assert property (p_oe_moves) else $error("enable moved off edge");
   property p_quiet;
      !spi_miso_oe |-> !spi_miso;
   endproperty
   a_quiet: assert property (p_quiet) else $error("miso high undriven");
   property p_hold;
      (!spi_cs_n && spi_sclk) [*2] |-> $stable(spi_miso) && $stable(spi_miso_oe);
   endproperty
   a_hold: assert property (p_hold) else $error("miso moved while clock high");
endmodule
bind mrr_motion_report mrr_sva u_sva (.clk_sys(clk_sys), .resetn(resetn),
   .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_miso(spi_miso),
   .spi_miso_oe(spi_miso_oe));

//--- dv/mrr_host.sv
// serial host model reading and writing the report registers
`timescale 1ns/1ps
module mrr_host (
   // serial port
   output logic spi_sclk,
   output logic spi_cs_n,
   output logic spi_mosi,
   input wire logic spi_miso
);
   initial begin
      spi_sclk = 1'b1;
      spi_cs_n = 1'b1;
      spi_mosi = 1'b0;
   end
   // clock stands high between frames
   task automatic xfer(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
      logic [15:0] w;
      w = {a, d};
      #3.7 spi_cs_n = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         #32 spi_sclk = 1'b0;
         spi_mosi = w[i];
         #32 spi_sclk = 1'b1;
         if (i < 8) q[i] = spi_miso;
         // slack so read data settles
         if (i == 8) #200;
      end
      #32 spi_cs_n = 1'b1;
      spi_mosi = ~spi_mosi;
      #100;
   endtask
   // status first, then X, then Y
   task automatic report(output logic [7:0] s, output logic [7:0] x, output logic [7:0] y);
      xfer(8'h02, 8'h00, s);
      xfer(8'h03, 8'h00, x);
      xfer(8'h04, 8'h00, y);
   endtask
endmodule

//--- dv/mrr_motion_report_tb.sv
// testbench for the motion report registers
`timescale 1ns/1ps
module mrr_motion_report_tb;
   import mrr_pkg::*;
   logic clk_sys, resetn, spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
   mrr_frame_s frame;
   logic [7:0] fw, s, x, y;
   int error_cnt = 0;
   int n_compared = 0;
   logic [14:0] rows [9] = '{{7'h00, 8'h5a}, {7'h01, 8'h02}, {7'h02, 8'h00},
      {7'h03, 8'h00}, {7'h04, 8'h00}, {7'h05, 8'h00}, {7'h0a, 8'h09},
      {7'h1f, 8'h3c}, {7'h07, 8'h00}};
   mrr_motion_report u_dut (.clk_sys(clk_sys), .resetn(resetn), .spi_sclk(spi_sclk),
      .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
      .spi_miso_oe(spi_miso_oe), .frame(frame), .firmware_revision_code(fw));
   mrr_host u_host (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
      .spi_miso(spi_miso));
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] exp);
      logic [7:0] q;
      u_host.xfer({1'b0, a}, 8'h00, q);
      check(q, exp);
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] q;
      u_host.xfer({1'b1, a}, d, q);
   endtask
   task automatic put(input logic [7:0] dx, input logic [7:0] dy, input logic [9:0] f);
      @(negedge clk_sys);
      frame = '{1'b1, dx, dy, f};
      @(negedge clk_sys);
      frame.valid = 1'b0;
   endtask
   task automatic print_verdict();
      if (error_cnt == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      #300000;
      error_cnt++;
      print_verdict();
   end
   initial begin
      resetn = 1'b0;
      frame = '0;
      fw = 8'h3c;
      repeat (20) @(negedge clk_sys);
      resetn = 1'b1;
      repeat (4) @(negedge clk_sys);
      foreach (rows[i]) rd(rows[i][14:8], rows[i][7:0]);
      // low resolution quarters the counts, floor on negatives
      put(8'h14, 8'hf7, 10'h3e8);
      u_host.report(s, x, y);
      check(s, 8'h80);
      check(x, 8'h05);
      check(y, 8'hfd);
      rd(MRR_ADDR_X_DISP, 8'h00);
      rd(MRR_ADDR_SURFACE, 8'ha9);
      put(8'h00, 8'h00, 10'h028);
      rd(MRR_ADDR_SURFACE, 8'h0a);
      rd(MRR_ADDR_STATUS, 8'h00);
      wr(MRR_ADDR_CONFIG, 8'h99);
      wr(MRR_ADDR_FLUSH, 8'h00);
      rd(MRR_ADDR_STATUS, 8'h01);
      rd(MRR_ADDR_CONFIG, 8'h19);
      // later motion must not leak into a frozen value
      put(8'h0a, 8'h00, 10'h000);
      rd(MRR_ADDR_STATUS, 8'h81);
      put(8'h07, 8'h00, 10'h000);
      rd(MRR_ADDR_X_DISP, 8'h0a);
      rd(MRR_ADDR_STATUS, 8'h81);
      put(8'h03, 8'h00, 10'h000);
      rd(MRR_ADDR_STATUS, 8'h81);
      rd(MRR_ADDR_X_DISP, 8'h03);
      rd(MRR_ADDR_Y_DISP, 8'h00);
      repeat (70) put(8'h7f, 8'h80, 10'h000);
      u_host.report(s, x, y);
      check(s, 8'h91);
      check(x, 8'h7f);
      check(y, 8'h80);
      u_host.report(s, x, y);
      check(s, 8'h81);
      check(x, 8'h7f);
      check(y, 8'h80);
      rd(MRR_ADDR_STATUS, 8'h81);
      wr(MRR_ADDR_FLUSH, 8'h00);
      rd(MRR_ADDR_X_DISP, 8'h00);
      rd(MRR_ADDR_STATUS, 8'h01);
      // saturated low resolution drain, host allows 16 reports
      wr(MRR_ADDR_CONFIG, 8'h09);
      repeat (70) put(8'h7f, 8'h80, 10'h000);
      for (int i = 0; i < 16; i++) begin
         u_host.report(s, x, y);
         check(s, (i == 0) ? 8'h90 : 8'h80);
         check(x, 8'h7f);
         check(y, 8'h80);
      end
      rd(MRR_ADDR_STATUS, 8'h00);
      wr(MRR_ADDR_CONFIG, 8'h19);
      // second reset in mid-run
      put(8'h05, 8'h00, 10'h000);
      resetn = 1'b0;
      repeat (4) @(negedge clk_sys);
      resetn = 1'b1;
      repeat (4) @(negedge clk_sys);
      rd(MRR_ADDR_STATUS, 8'h00);
      rd(MRR_ADDR_CONFIG, 8'h09);
      print_verdict();
   end
endmodule
